// *** hw/dtc_pkg.sv ***
package dtc_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_TIMER_A_CONTROL = 8'hB0;
	localparam logic [7:0] ADDR_TIMER_A_REFERENCE = 8'hB1;
	localparam logic [7:0] ADDR_TIMER_A_COUNT = 8'hB2;
	localparam logic [7:0] ADDR_TIMER_B_CONTROL = 8'hB3;
	localparam logic [7:0] ADDR_TIMER_B_REFERENCE = 8'hB4;
	localparam logic [7:0] ADDR_TIMER_B_COUNT = 8'hB5;
	localparam logic [7:0] ADDR_INTERRUPT_ENABLE_HIGH = 8'hB6;
	localparam logic [7:0] ADDR_INTERRUPT_REQUEST_HIGH = 8'hB7;

	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int CASCADE_BIT = 7;
	localparam int MODE_HI = 6;
	localparam int MODE_LO = 5;
	localparam int CLEAR_BIT = 4;
	localparam int CLOCK_HI = 3;
	localparam int CLOCK_LO = 0;

	// Interrupt bit positions in enable and request registers
	localparam int IRQ_A_MATCH = 7;
	localparam int IRQ_A_OVF = 6;
	localparam int IRQ_B_MATCH = 5;
	localparam int IRQ_B_OVF = 4;
	localparam logic [7:0] IRQ_USED_MASK = 8'hF0;

	// ------------------------------------------------------------
	// Mode and clock codes
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_INTERVAL = 2'h0;
	localparam logic [1:0] MODE_PWM = 2'h1;

	localparam logic [3:0] CLK_STOP = 4'h0;
	localparam logic [3:0] CLK_EXT_RISE = 4'h5;
	localparam logic [3:0] CLK_EXT_FALL = 4'h6;
	localparam logic [3:0] CLK_SUB = 4'h7;

	localparam int PRESCALE_WIDTH = 11;

	typedef struct packed {
		logic cascade;
		logic [1:0] mode;
		logic clear;
		logic [3:0] clock;
	} dtc_control_type;

	typedef struct packed {
		logic a_match;
		logic a_ovf;
		logic b_match;
		logic b_ovf;
	} dtc_events_type;

endpackage

// *** hw/dtc_clock_select.sv ***
`timescale 1ns/100ps
`default_nettype none

module dtc_clock_select
	import dtc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Selection
	input wire logic [3:0] clock_field,
	input wire logic timer_b_table,
	// Sources
	input wire logic [PRESCALE_WIDTH-1:0] prescale,
	input wire logic sub_tick,
	input wire logic ext_pin,
	// Result
	output logic count_tick
);

	// ------------------------------------------------------------
	// External pin synchroniser and edge detect
	// ------------------------------------------------------------
	logic ext_meta_q;
	logic ext_sync_q;
	logic ext_last_q;
	logic [PRESCALE_WIDTH-1:0] prev_q;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ext_meta_q <= 1'b0;
			ext_sync_q <= 1'b0;
			ext_last_q <= 1'b0;
		end
		else
		begin
			ext_meta_q <= ext_pin; // [R16]
			ext_sync_q <= ext_meta_q; // [R16]
			ext_last_q <= ext_sync_q; // [R16]
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			prev_q <= '0;
		else
			prev_q <= prescale;
	end

	// Divider tap: index into the prescaler; a bit's falling edge marks one period
	logic [3:0] tap;
	logic div_tick;

	always_comb
	begin
		tap = 4'h0;
		unique case (clock_field[2:0])
			3'h0: tap = timer_b_table ? 4'hF : 4'h0;
			3'h1: tap = timer_b_table ? 4'h0 : 4'h1;
			3'h2: tap = timer_b_table ? 4'h1 : 4'h2;
			3'h3: tap = timer_b_table ? 4'h2 : 4'h3;
			3'h4: tap = timer_b_table ? 4'h3 : 4'h4;
			3'h5: tap = timer_b_table ? 4'h5 : 4'h6;
			3'h6: tap = timer_b_table ? 4'h7 : 4'h8;
			3'h7: tap = timer_b_table ? 4'h9 : 4'hA;
		endcase
		if (tap == 4'hF)
			div_tick = 1'b1; // [R10]
		else
			div_tick = prev_q[tap] && !prescale[tap]; // [R8] [R10]
	end

	always_comb
	begin
		if (clock_field[3])
			count_tick = div_tick; // [R8] [R10]
		else if (clock_field == CLK_EXT_RISE)
			count_tick = ext_sync_q && !ext_last_q; // [R8] [R9] [R16]
		else if (clock_field == CLK_EXT_FALL)
			count_tick = !ext_sync_q && ext_last_q; // [R8] [R9] [R16]
		else if (clock_field == CLK_SUB)
			count_tick = sub_tick; // [R8] [R10]
		else
			count_tick = 1'b0; // [R8] [R9] [R17]
	end

endmodule
`default_nettype wire

// *** hw/dtc_dual_timer.sv ***
// Behaviour
// (R1) Timer A match request only when its enable is set; flag cleared on service.
// (R2) Timer A overflow request only when enabled; flag cleared on service.
// (R3) Timer B match request gated by its enable; flag cleared on service.
// (R4) Timer B overflow request gated by its enable; flag cleared on service.
// (R5) Control A bit 7 picks two 8-bit timers or one 16-bit timer.
// (R6) Mode field: 00 interval, 01 PWM, 1X capture.
// (R7) Writing 1 to clear bit zeroes counter, bit self-returns to 0.
// (R8) Timer A clock field: stop, external edges, sub clock, prescaled system clock.
// (R9) Timer B clock field: stop, unavailable codes, own external pin edges.
// (R10) Timer B clock: sub clock or system clock divided 1 to 1024.
// (R11) Timer B compares against a buffer loaded from reference on clear.
// (R12) Interval mode match toggles output, requests interrupt, clears counter.
// (R13) PWM mode counter wraps; output high while reference exceeds count.
// (R14) Capture pin copies count into reference then clears counter.
// (R15) 16-bit mode joins counters; timer B is the high byte.
// (R16) External clock pins are synchronised before counting.
// (R17) Unavailable clock codes behave as stop.
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
`default_nettype none

module dtc_dual_timer
	import dtc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	// Interrupt service acknowledges
	input wire logic [3:0] irq_service,
	// Timer pins
	input wire logic sub_clock_tick,
	input wire logic timer_a_ext_clock_pin,
	input wire logic timer_b_ext_clock_pin,
	input wire logic timer_a_capture_pin,
	input wire logic timer_b_capture_pin,
	output logic timer_a_toggle_out,
	output logic timer_a_pwm_out,
	output logic timer_b_toggle_out,
	output logic timer_b_pwm_out,
	// Interrupt
	output logic irq
);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	dtc_control_type ctl_a_q;
	dtc_control_type ctl_b_q;
	logic [7:0] ref_a_q;
	logic [7:0] ref_b_q;
	logic [7:0] buf_b_q;
	logic [7:0] cnt_a_q;
	logic [7:0] cnt_b_q;
	logic [7:0] ien_q;
	dtc_events_type req_q;
	logic [PRESCALE_WIDTH-1:0] prescale_q;
	logic tog_a_q;
	logic tog_b_q;
	logic pwm_a_q;
	logic pwm_b_q;
	logic cap_a_q;
	logic cap_b_q;
	logic [7:0] rdata_q;

	logic wr_ctl_a;
	logic wr_ctl_b;
	logic wr_ref_a;
	logic wr_ref_b;
	logic wr_ien;
	logic wr_req;

	always_comb
	begin
		wr_ctl_a = reg_write && reg_addr == ADDR_TIMER_A_CONTROL;
		wr_ctl_b = reg_write && reg_addr == ADDR_TIMER_B_CONTROL;
		wr_ref_a = reg_write && reg_addr == ADDR_TIMER_A_REFERENCE;
		wr_ref_b = reg_write && reg_addr == ADDR_TIMER_B_REFERENCE;
		wr_ien = reg_write && reg_addr == ADDR_INTERRUPT_ENABLE_HIGH;
		wr_req = reg_write && reg_addr == ADDR_INTERRUPT_REQUEST_HIGH;
	end

	// ------------------------------------------------------------
	// Prescaler and clock selection
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			prescale_q <= '0;
		else
			prescale_q <= prescale_q + 1'b1;
	end

	logic tick_a;
	logic tick_b_raw;
	logic cascade;

	dtc_clock_select u_clk_a
	(
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clock_field(ctl_a_q.clock),
		.timer_b_table(1'b0),
		.prescale(prescale_q),
		.sub_tick(sub_clock_tick),
		.ext_pin(timer_a_ext_clock_pin),
		.count_tick(tick_a)
	);

	dtc_clock_select u_clk_b
	(
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clock_field(ctl_b_q.clock),
		.timer_b_table(1'b1),
		.prescale(prescale_q),
		.sub_tick(sub_clock_tick),
		.ext_pin(timer_b_ext_clock_pin),
		.count_tick(tick_b_raw)
	);

	// ------------------------------------------------------------
	// Capture pin edge detect (rising)
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cap_a_q <= 1'b0;
			cap_b_q <= 1'b0;
		end
		else
		begin
			cap_a_q <= timer_a_capture_pin;
			cap_b_q <= timer_b_capture_pin;
		end
	end

	logic cap_a_ev;
	logic cap_b_ev;
	logic capture_a;
	logic capture_b;

	// ------------------------------------------------------------
	// Compare and events
	// ------------------------------------------------------------
	logic [15:0] cnt16;
	logic [15:0] ref16;
	logic [1:0] mode_a;
	logic [1:0] mode_b;
	logic match_a;
	logic match_b;
	logic ovf_a;
	logic ovf_b;
	logic clr_a;
	logic clr_b;
	logic tick_b;
	dtc_events_type ev;

	always_comb
	begin
		cascade = ctl_a_q.cascade; // [R5]
		mode_a = ctl_a_q.mode;
		mode_b = ctl_b_q.mode;
		cap_a_ev = timer_a_capture_pin && !cap_a_q;
		cap_b_ev = timer_b_capture_pin && !cap_b_q;
		capture_a = mode_a[1] && cap_a_ev; // [R6] [R14]
		capture_b = !cascade && mode_b[1] && cap_b_ev; // [R6] [R14]
		cnt16 = {cnt_b_q, cnt_a_q}; // [R15]
		ref16 = {buf_b_q, ref_a_q}; // [R15] [R11]
		tick_b = cascade ? (tick_a && cnt_a_q == 8'hFF) : tick_b_raw; // [R5] [R15]
		if (cascade)
		begin
			match_a = tick_a && !mode_a[1] && cnt16 == ref16; // [R15]
			ovf_a = tick_a && mode_a != MODE_INTERVAL && cnt16 == 16'hFFFF; // [R15] [R6]
			match_b = 1'b0;
			ovf_b = 1'b0;
		end
		else
		begin
			match_a = tick_a && !mode_a[1] && cnt_a_q == ref_a_q; // [R12] [R13]
			ovf_a = tick_a && mode_a != MODE_INTERVAL && cnt_a_q == 8'hFF; // [R6] [R14]
			match_b = tick_b && !mode_b[1] && cnt_b_q == buf_b_q; // [R11] [R12]
			ovf_b = tick_b && mode_b != MODE_INTERVAL && cnt_b_q == 8'hFF; // [R6]
		end
		clr_a = (wr_ctl_a && reg_wdata[CLEAR_BIT]) || capture_a
			|| (match_a && mode_a == MODE_INTERVAL); // [R7] [R12] [R14]
		clr_b = (wr_ctl_b && reg_wdata[CLEAR_BIT]) || capture_b || (cascade && clr_a)
			|| (wr_ctl_a && reg_wdata[CLEAR_BIT] && reg_wdata[CASCADE_BIT])
			|| (match_b && mode_b == MODE_INTERVAL); // [R7] [R12] [R15]
		ev.a_match = match_a;
		ev.a_ovf = ovf_a;
		ev.b_match = match_b;
		ev.b_ovf = ovf_b;
	end

	// ------------------------------------------------------------
	// Control registers (clear bit always reads back 0)
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctl_a_q <= CONTROL_RESET;
			ctl_b_q <= CONTROL_RESET;
		end
		else
		begin
			if (wr_ctl_a)
				ctl_a_q <= {reg_wdata[7:5], 1'b0, reg_wdata[3:0]}; // [R5] [R6] [R7] [R8]
			if (wr_ctl_b)
				ctl_b_q <= {1'b0, reg_wdata[6:5], 1'b0, reg_wdata[3:0]}; // [R6] [R7] [R9]
		end
	end

	// ------------------------------------------------------------
	// Counters
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_a_q <= BYTE_ZERO;
			cnt_b_q <= BYTE_ZERO;
		end
		else
		begin
			if (clr_a)
				cnt_a_q <= BYTE_ZERO; // [R7] [R12]
			else if (tick_a)
				cnt_a_q <= cnt_a_q + 1'b1; // [R13]
			if (clr_b)
				cnt_b_q <= BYTE_ZERO; // [R7] [R12]
			else if (tick_b)
				cnt_b_q <= cnt_b_q + 1'b1; // [R13] [R15]
		end
	end

	// ------------------------------------------------------------
	// Reference and buffer registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ref_a_q <= BYTE_ZERO;
			ref_b_q <= BYTE_ZERO;
		end
		else
		begin
			if (capture_a)
				ref_a_q <= cnt_a_q; // [R14]
			else if (wr_ref_a)
				ref_a_q <= reg_wdata;
			if (capture_b || (cascade && capture_a))
				ref_b_q <= cnt_b_q; // [R14] [R15]
			else if (wr_ref_b)
				ref_b_q <= reg_wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			buf_b_q <= BYTE_ZERO;
		else if (reg_wdata[CLEAR_BIT] && (wr_ctl_b || (wr_ctl_a && reg_wdata[CASCADE_BIT])))
			buf_b_q <= ref_b_q; // [R11] [R15]
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tog_a_q <= 1'b0;
			tog_b_q <= 1'b0;
		end
		else
		begin
			if (match_a && mode_a == MODE_INTERVAL)
				tog_a_q <= !tog_a_q; // [R12]
			if (match_b && mode_b == MODE_INTERVAL)
				tog_b_q <= !tog_b_q; // [R12]
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pwm_a_q <= 1'b0;
			pwm_b_q <= 1'b0;
		end
		else
		begin
			pwm_a_q <= mode_a == MODE_PWM && (cascade ? ref16 > cnt16 : ref_a_q > cnt_a_q); // [R13]
			pwm_b_q <= !cascade && mode_b == MODE_PWM && buf_b_q > cnt_b_q; // [R13]
		end
	end

	always_comb
	begin
		timer_a_toggle_out = tog_a_q;
		timer_b_toggle_out = tog_b_q;
		timer_a_pwm_out = pwm_a_q;
		timer_b_pwm_out = pwm_b_q;
	end

	// ------------------------------------------------------------
	// Interrupt enable and request
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			ien_q <= BYTE_ZERO;
		else if (wr_ien)
			ien_q <= reg_wdata & IRQ_USED_MASK;
	end

	// Set wins over a same-cycle clear by service or write-one
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			req_q <= '0;
		else
			req_q <= ev | (req_q & ~irq_service
				& ~({4{wr_req}} & reg_wdata[IRQ_A_MATCH:IRQ_B_OVF])); // [R1] [R2] [R3] [R4]
	end

	always_comb
	begin
		irq = |(req_q & ien_q[IRQ_A_MATCH:IRQ_B_OVF]); // [R1] [R2] [R3] [R4]
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_q <= BYTE_ZERO;
		else if (reg_read)
		begin
			unique case (reg_addr)
				ADDR_TIMER_A_CONTROL: rdata_q <= ctl_a_q;
				ADDR_TIMER_B_CONTROL: rdata_q <= ctl_b_q;
				ADDR_TIMER_A_REFERENCE: rdata_q <= ref_a_q;
				ADDR_TIMER_B_REFERENCE: rdata_q <= ref_b_q;
				ADDR_TIMER_A_COUNT: rdata_q <= cnt_a_q;
				ADDR_TIMER_B_COUNT: rdata_q <= cnt_b_q;
				ADDR_INTERRUPT_ENABLE_HIGH: rdata_q <= ien_q;
				ADDR_INTERRUPT_REQUEST_HIGH: rdata_q <= {req_q, 4'h0};
				default: rdata_q <= BYTE_ZERO;
			endcase
		end
		else
			rdata_q <= BYTE_ZERO;
	end

	always_comb
	begin
		reg_rdata = rdata_q;
	end

endmodule
`default_nettype wire

// *** verif/dtc_dual_timer_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module dtc_dual_timer_props
	import dtc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	// Events and outputs
	input wire logic [3:0] irq_service,
	input wire logic timer_a_toggle_out,
	input wire logic timer_a_pwm_out,
	input wire logic timer_b_pwm_out,
	input wire logic irq
);
	// ----
	// Shadow of control A and enables
	// ----
	logic [7:0] ctl_a_q;
	logic [3:0] en_q;
	logic stop_a;
	assign stop_a = ctl_a_q[3:0] < 4'h5;
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctl_a_q <= 8'h00;
			en_q <= 4'h0;
		end
		else if (reg_write)
		begin
			if (reg_addr == ADDR_TIMER_A_CONTROL)
				ctl_a_q <= reg_wdata;
			if (reg_addr == ADDR_INTERRUPT_ENABLE_HIGH)
				en_q <= reg_wdata[7:4];
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	chk_clear_reads_zero:
		assert property (reg_read && (reg_addr == ADDR_TIMER_A_CONTROL
			|| reg_addr == ADDR_TIMER_B_CONTROL) |=> !reg_rdata[CLEAR_BIT])
		else $error("clear bit read back as one");
	chk_b_top_zero:
		assert property (reg_read && reg_addr == ADDR_TIMER_B_CONTROL |=> !reg_rdata[7])
		else $error("control B bit 7 read as one");
	chk_clear_count:
		assert property (reg_write && reg_addr == ADDR_TIMER_A_CONTROL && reg_wdata[4]
			&& reg_wdata[3:0] < 4'h5 ##2 reg_read && reg_addr == ADDR_TIMER_A_COUNT
			|=> reg_rdata == 8'h00)
		else $error("count not zero after clear");
	chk_irq_masked:
		assert property (en_q == 4'h0 |-> !irq)
		else $error("irq with all enables off");
	chk_service_clears:
		assert property (stop_a && $past(stop_a) && $past(stop_a, 2) && en_q == 4'h8
			&& irq_service[3] |=> !irq)
		else $error("match service left irq high");
	chk_a_pwm_mode:
		assert property (ctl_a_q[6:5] != MODE_PWM && $past(ctl_a_q[6:5]) != MODE_PWM
			|-> !timer_a_pwm_out)
		else $error("pwm A high outside pwm mode");
	chk_cascade_b_quiet:
		assert property (ctl_a_q[7] && $past(ctl_a_q[7]) |-> !timer_b_pwm_out)
		else $error("pwm B active in cascade");
	chk_stop_toggle:
		assert property (stop_a && $past(stop_a) && $past(stop_a, 2)
			|=> $stable(timer_a_toggle_out))
		else $error("toggle A moved while stopped");
	cover property (irq_service[3] && irq);
	cover property (ctl_a_q[7] && irq);
	cover property ($rose(timer_b_pwm_out));
endmodule
bind dtc_dual_timer dtc_dual_timer_props dtc_dual_timer_props_i (.ref_clk(ref_clk),
	.rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
	.reg_read(reg_read), .reg_rdata(reg_rdata), .irq_service(irq_service),
	.timer_a_toggle_out(timer_a_toggle_out), .timer_a_pwm_out(timer_a_pwm_out),
	.timer_b_pwm_out(timer_b_pwm_out), .irq(irq));
`default_nettype wire

// *** verif/dtc_pin_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module dtc_pin_model
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Requests from the bench
	input wire logic [1:0] ext_req,
	input wire logic [1:0] cap_req,
	// Pins
	output logic [1:0] ext_pin,
	output logic [1:0] cap_pin,
	output logic sub_tick
);
	logic [1:0][3:0] ext_q;
	logic [1:0][3:0] cap_q;
	logic [2:0] div_q;
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ext_q <= '0;
			cap_q <= '0;
			div_q <= 3'h0;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				ext_q[i] <= ext_req[i] ? 4'h8 : ext_q[i] - 4'(ext_q[i] != 4'h0);
				cap_q[i] <= cap_req[i] ? 4'h8 : cap_q[i] - 4'(cap_q[i] != 4'h0);
			end
			div_q <= div_q + 3'h1;
		end
	end
	// Pins high four cycles, then low: one clean edge each way
	assign ext_pin = {ext_q[1] > 4'h4, ext_q[0] > 4'h4};
	assign cap_pin = {cap_q[1] > 4'h4, cap_q[0] > 4'h4};
	// Free running sub clock, one tick every eight cycles
	assign sub_tick = div_q == 3'h7;
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import dtc_pkg::*;
;
	logic ref_clk, rst_n, reg_write, reg_read, irq, sub_tick, a_tog, a_pwm, b_tog, b_pwm;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic [3:0] irq_service;
	logic [1:0] ext_req, cap_req, ext_pin, cap_pin;
	logic b;
	int fail_count, checks_done, n;
	dtc_dual_timer dtc_dual_timer_i (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .irq_service(irq_service), .sub_clock_tick(sub_tick),
		.timer_a_ext_clock_pin(ext_pin[0]), .timer_b_ext_clock_pin(ext_pin[1]),
		.timer_a_capture_pin(cap_pin[0]), .timer_b_capture_pin(cap_pin[1]),
		.timer_a_toggle_out(a_tog), .timer_a_pwm_out(a_pwm), .timer_b_toggle_out(b_tog),
		.timer_b_pwm_out(b_pwm), .irq(irq));
	dtc_pin_model dtc_pin_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .ext_req(ext_req),
		.cap_req(cap_req), .ext_pin(ext_pin), .cap_pin(cap_pin), .sub_tick(sub_tick));
	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	// ----
	// Shared tasks
	// ----
	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
	endtask
	task automatic finish_test;
		if (fail_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rng(input logic [15:0] v, input int lo, input int hi);
		chk({15'h0000, v >= 16'(lo) && v <= 16'(hi)}, 16'h0001);
	endtask
	task automatic irq_is(input logic e);
		chk({15'h0000, irq}, {15'h0000, e});
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_write <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		@(posedge ref_clk);
		d = reg_rdata;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk({8'h00, d}, {8'h00, e});
	endtask
	task automatic svc(input logic [3:0] m);
		irq_service <= m;
		@(posedge ref_clk);
		irq_service <= 4'h0;
	endtask
	task automatic pulse(input logic [1:0] e, input logic [1:0] c);
		ext_req <= e;
		cap_req <= c;
		@(posedge ref_clk);
		ext_req <= 2'h0;
		cap_req <= 2'h0;
		tick(12);
	endtask
	task automatic wait_irq;
		n = 0;
		while (irq !== 1'b1)
		begin
			if (n == 1000)
			begin
				fail_count++;
				finish_test;
			end
			@(posedge ref_clk);
			n++;
		end
	endtask
	task automatic duty(input logic sel);
		n = 0;
		repeat (512)
		begin
			@(posedge ref_clk);
			if ((sel ? a_pwm : b_pwm) === 1'b1)
				n++;
		end
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_reset;
		rdc(ADDR_TIMER_A_CONTROL, CONTROL_RESET);
		rdc(ADDR_TIMER_B_CONTROL, CONTROL_RESET);
		rdc(8'hC0, BYTE_ZERO);
	endtask
	task automatic t_interval;
		wr(ADDR_TIMER_A_REFERENCE, 8'h05);
		wr(ADDR_TIMER_A_CONTROL, 8'h18);
		tick(40);
		wr(ADDR_TIMER_A_CONTROL, 8'h00);
		tick(3);
		irq_is(1'b0);
		rdc(ADDR_INTERRUPT_REQUEST_HIGH, 8'h80);
		rd(ADDR_TIMER_A_COUNT);
		rng({8'h00, d}, 0, 5);
		wr(ADDR_INTERRUPT_ENABLE_HIGH, 8'h80);
		tick(1);
		irq_is(1'b1);
		svc(4'h8);
		tick(1);
		irq_is(1'b0);
		rdc(ADDR_INTERRUPT_REQUEST_HIGH, 8'h00);
		b = a_tog;
		wr(ADDR_TIMER_A_CONTROL, 8'h18);
		tick(16);
		wr(ADDR_TIMER_A_CONTROL, 8'h00);
		tick(3);
		chk({15'h0000, a_tog}, {15'h0000, ~b});
		svc(4'h8);
	endtask
	task automatic t_pwm;
		wr(ADDR_TIMER_B_REFERENCE, 8'h80);
		wr(ADDR_INTERRUPT_ENABLE_HIGH, 8'h10);
		wr(ADDR_TIMER_B_CONTROL, 8'h38);
		duty(1'b0);
		rng(16'(n), 253, 259);
		wr(ADDR_TIMER_B_CONTROL, 8'h20);
		tick(3);
		irq_is(1'b1);
		rdc(ADDR_INTERRUPT_REQUEST_HIGH, 8'h30);
		svc(4'h1);
		tick(1);
		irq_is(1'b0);
		rdc(ADDR_INTERRUPT_REQUEST_HIGH, 8'h20);
		wr(ADDR_TIMER_B_REFERENCE, 8'h40);
		wr(ADDR_TIMER_B_CONTROL, 8'h28);
		duty(1'b0);
		rng(16'(n), 253, 259);
		wr(ADDR_TIMER_B_CONTROL, 8'h38);
		duty(1'b0);
		rng(16'(n), 125, 131);
		wr(ADDR_TIMER_A_REFERENCE, 8'h80);
		wr(ADDR_TIMER_A_CONTROL, 8'h38);
		duty(1'b1);
		rng(16'(n), 253, 259);
		wr(ADDR_TIMER_A_CONTROL, 8'h00);
		wr(ADDR_TIMER_B_CONTROL, 8'h00);
		wr(ADDR_INTERRUPT_ENABLE_HIGH, 8'h00);
		rdc(ADDR_INTERRUPT_REQUEST_HIGH, 8'hF0);
		wr(ADDR_INTERRUPT_REQUEST_HIGH, 8'hF0);
		rdc(ADDR_INTERRUPT_REQUEST_HIGH, 8'h00);
	endtask
	task automatic t_ext;
		wr(ADDR_TIMER_B_REFERENCE, 8'h01);
		wr(ADDR_TIMER_B_CONTROL, 8'h15);
		b = b_tog;
		repeat (2) pulse(2'h2, 2'h0);
		chk({15'h0000, b_tog}, {15'h0000, ~b});
		wr(ADDR_TIMER_B_CONTROL, 8'h55);
		repeat (3) pulse(2'h2, 2'h0);
		rdc(ADDR_TIMER_B_COUNT, 8'h03);
		wr(ADDR_TIMER_B_CONTROL, 8'h56);
		repeat (2) pulse(2'h2, 2'h0);
		rdc(ADDR_TIMER_B_COUNT, 8'h02);
		wr(ADDR_TIMER_B_CONTROL, 8'h46);
		rdc(ADDR_TIMER_B_COUNT, 8'h02);
		pulse(2'h0, 2'h2);
		rdc(ADDR_TIMER_B_REFERENCE, 8'h02);
		rdc(ADDR_TIMER_B_COUNT, 8'h00);
	endtask
	task automatic t_capture;
		wr(ADDR_TIMER_A_CONTROL, 8'h78);
		tick(100);
		pulse(2'h0, 2'h1);
		rd(ADDR_TIMER_A_REFERENCE);
		rng({8'h00, d}, 45, 60);
		rd(ADDR_TIMER_A_COUNT);
		rng({8'h00, d}, 0, 16);
	endtask
	task automatic t_sweep(input logic [7:0] ca, input logic [7:0] na, input int sh [8]);
		int e;
		for (int k = 0; k < 8; k++)
		begin
			e = 64 >> sh[k];
			wr(ca, 8'h58 + 8'(k));
			tick(64);
			rd(na);
			rng({8'h00, d}, e > 0 ? e - 1 : 0, e + 2);
		end
	endtask
	task automatic t_cascade;
		wr(ADDR_TIMER_B_CONTROL, 8'h00);
		wr(ADDR_INTERRUPT_REQUEST_HIGH, 8'hF0);
		wr(ADDR_TIMER_A_REFERENCE, 8'h04);
		wr(ADDR_TIMER_B_REFERENCE, 8'h01);
		wr(ADDR_INTERRUPT_ENABLE_HIGH, 8'h80);
		wr(ADDR_TIMER_A_CONTROL, 8'h98);
		wait_irq;
		rng(16'(n), 505, 540);
		wr(ADDR_TIMER_A_CONTROL, 8'h80);
		tick(3);
		rdc(ADDR_INTERRUPT_REQUEST_HIGH, 8'h80);
		svc(4'h8);
		tick(1);
		irq_is(1'b0);
	endtask
	task automatic t_stop_sub;
		wr(ADDR_TIMER_A_CONTROL, 8'h13);
		rdc(ADDR_TIMER_A_COUNT, 8'h00);
		tick(40);
		rdc(ADDR_TIMER_A_COUNT, 8'h00);
		wr(ADDR_TIMER_B_CONTROL, 8'h57);
		tick(80);
		rd(ADDR_TIMER_B_COUNT);
		rng({8'h00, d}, 9, 11);
	endtask
	initial
	begin
		fail_count = 0;
		checks_done = 0;
		rst_n = 1'b0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		irq_service = 4'h0;
		ext_req = 2'h0;
		cap_req = 2'h0;
		tick(20);
		rst_n <= 1'b1;
		tick(1);
		t_reset;
		t_interval;
		t_pwm;
		t_ext;
		t_capture;
		t_sweep(ADDR_TIMER_A_CONTROL, ADDR_TIMER_A_COUNT, '{1, 2, 3, 4, 5, 7, 9, 11});
		t_sweep(ADDR_TIMER_B_CONTROL, ADDR_TIMER_B_COUNT, '{0, 1, 2, 3, 4, 6, 8, 10});
		t_cascade;
		t_stop_sub;
		finish_test;
	end
endmodule
`default_nettype wire
